//--- verilog/config_integrity.sv
// power-up integrity checks, test port enable, watchdog and flash write path
// Contract
// - test port stays off by default; shared pins act as GPIO.
// - four of six test port pins serve as GPIO when port is off.
// - blank data flash at power-up enables the test port.
// - strapped address 126 at power-up enables the test port.
// - either address strap shorted or open decodes to address 126.
// - test port serves programming only, no boundary scan.
// - bad firmware checksum blocks firmware but bus commands still accepted.
// - bad configuration checksum loads factory default configuration.
// - bad configuration checksum asserts alert and sets status flag.
// - a checksum over the fault log guards the log flash region.
// - firmware watchdog timeout causes a normal device reset.
// - during any reset GPIO float open-drain and fast PWM drives low.
// - every passed parameter is range-checked before use.
// - six check bits are generated with every written 32-bit word.
// - every data flash read corrects any single-bit error.
// - after in-operation rewrite, keep old config, fault logging off, until reset.
// - after each reset, bad fault-log checksum erases the log.
`timescale 1ns/100ps
`default_nettype none
`include "config_integrity_defs.svh"
module config_integrity #(
    parameter int WDT_CYCLES = `WDT_CYCLES,
    parameter int FW_WORDS = `FW_WORDS,
    parameter int CFG_WORDS = `CFG_WORDS,
    parameter int LOG_WORDS = `LOG_WORDS,
    parameter int AW = `FLASH_AW
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic [3:0] addrStrapHi,
    input wire logic [3:0] addrStrapLo,
    output logic flashRdReq,
    output logic [AW-1:0] flashRdAddr,
    input wire config_integrity_pkg::code_word_t flashRdWord,
    input wire logic flashRdAck,
    output logic flashLogEraseReq,
    input wire logic flashEraseDone,
    input wire logic progWpOff,
    input wire logic progEraseReq,
    input wire logic progWrValid,
    input wire logic [AW-1:0] progWrAddr,
    input wire logic [31:0] progWrData,
    output logic flashWrEn,
    output logic [AW-1:0] flashWrAddr,
    output config_integrity_pkg::code_word_t flashWrWord,
    output logic flashChipEraseReq,
    input wire logic paramValid,
    input wire logic [`PARAM_W-1:0] paramValue,
    input wire logic [`PARAM_W-1:0] paramMin,
    input wire logic [`PARAM_W-1:0] paramMax,
    output logic paramAccept,
    output logic paramReject,
    output logic [`PARAM_W-1:0] paramReg,
    input wire logic wdKick,
    input wire logic [3:0] pinIn,
    input wire logic [3:0] appGpioOut,
    input wire logic [3:0] appGpioOe,
    input wire logic tapTdo,
    output logic [3:0] pinOut,
    output logic [3:0] pinOe,
    output logic [2:0] tapIn,
    output logic testPortEn,
    input wire logic appPwm,
    output logic fast_pwm_out,
    input wire logic alertClear,
    output logic fwRunEn,
    output logic cfgDefaultSel,
    output logic cfgCrcFlag,
    output logic logEnable,
    output logic initDone,
    output logic eccFixPulse,
    output logic bus_alert_out_n
);
    localparam int TOTAL = FW_WORDS + CFG_WORDS + LOG_WORDS;
    localparam logic [AW-1:0] FW_END = AW'(FW_WORDS - 1);
    localparam logic [AW-1:0] CFG_END = AW'(FW_WORDS + CFG_WORDS - 1);
    localparam logic [AW-1:0] LOG_END = AW'(TOTAL - 1);
    localparam logic [31:0] WDT_LAST = 32'(WDT_CYCLES - 1);

    config_integrity_pkg::init_state_e state_reg;
    ecc_if eccBus ();
    ecc_hamming uEcc (
        .ecc(eccBus.codec)
    );
    assign eccBus.wrData = progWrData;
    assign eccBus.rdWord = flashRdWord;

    // strap and pin synchronisers
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    logic [11:0] sync3_reg;
    logic [11:0] syncStable_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_reg <= 12'h000;
            sync2_reg <= 12'h000;
            sync3_reg <= 12'h000;
            syncStable_reg <= 12'h000;
        end else if (clkEn) begin
            sync1_reg <= {pinIn, addrStrapHi, addrStrapLo};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            for (int i = 0; i < 12; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    syncStable_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    logic [3:0] strapHi;
    logic [3:0] strapLo;
    logic [6:0] addrDecoded;
    assign strapHi = syncStable_reg[7:4];
    assign strapLo = syncStable_reg[3:0];
    always_comb begin
        if (strapHi == `STRAP_SHORT || strapHi == `STRAP_OPEN ||
            strapLo == `STRAP_SHORT || strapLo == `STRAP_OPEN) begin
            addrDecoded = `ADDR_TESTPORT;
        end else begin
            addrDecoded = {strapHi[2:0], strapLo};
        end
    end

    // watchdog and internal reset stretch
    logic [31:0] wdCnt_reg;
    logic [3:0] wdHold_reg;
    logic softRst;
    logic wdFire;
    assign softRst = (wdHold_reg != 4'h0);
    assign wdFire = fwRunEn && (state_reg == config_integrity_pkg::ST_RUN) &&
        !wdKick && (wdCnt_reg == WDT_LAST);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdCnt_reg <= 32'h00000000;
            wdHold_reg <= 4'h0;
        end else if (clkEn) begin
            if (wdFire) begin
                wdCnt_reg <= 32'h00000000;
                wdHold_reg <= `RST_HOLD;
            end else begin
                if (softRst) begin
                    wdHold_reg <= wdHold_reg - 4'h1;
                end
                if (wdKick || !fwRunEn || softRst) begin
                    wdCnt_reg <= 32'h00000000;
                end else begin
                    wdCnt_reg <= wdCnt_reg + 32'h00000001;
                end
            end
        end
    end

    // power-up scan of firmware, configuration and log regions
    logic [AW-1:0] idx_reg;
    logic [31:0] sum_reg;
    logic blank_reg;
    logic fwBad_reg;
    logic cfgBad_reg;
    logic logBad_reg;
    logic [31:0] rdWord;
    logic regionEnd;
    logic sumBad;
    assign rdWord = eccBus.rdData;
    assign regionEnd = (idx_reg == FW_END) || (idx_reg == CFG_END) || (idx_reg == LOG_END);
    assign sumBad = (sum_reg != rdWord);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= config_integrity_pkg::ST_IDLE;
            idx_reg <= '0;
            sum_reg <= 32'h00000000;
            blank_reg <= 1'b1;
            fwBad_reg <= 1'b0;
            cfgBad_reg <= 1'b0;
            logBad_reg <= 1'b0;
            flashRdReq <= 1'b0;
            flashRdAddr <= '0;
            flashLogEraseReq <= 1'b0;
            eccFixPulse <= 1'b0;
        end else if (clkEn) begin
            flashLogEraseReq <= 1'b0;
            eccFixPulse <= 1'b0;
            if (softRst) begin
                state_reg <= config_integrity_pkg::ST_IDLE;
                flashRdReq <= 1'b0;
            end else begin
                case (state_reg)
                    config_integrity_pkg::ST_IDLE: begin
                        idx_reg <= '0;
                        sum_reg <= 32'h00000000;
                        blank_reg <= 1'b1;
                        fwBad_reg <= 1'b0;
                        cfgBad_reg <= 1'b0;
                        logBad_reg <= 1'b0;
                        state_reg <= config_integrity_pkg::ST_REQ;
                    end
                    config_integrity_pkg::ST_REQ: begin
                        flashRdReq <= 1'b1;
                        flashRdAddr <= idx_reg;
                        state_reg <= config_integrity_pkg::ST_WAIT;
                    end
                    config_integrity_pkg::ST_WAIT: begin
                        if (flashRdAck) begin
                            flashRdReq <= 1'b0;
                            eccFixPulse <= eccBus.rdCorrected;
                            if (rdWord != `BLANK_WORD) begin
                                blank_reg <= 1'b0;
                            end
                            if (regionEnd) begin
                                sum_reg <= 32'h00000000;
                                if (idx_reg == FW_END) begin
                                    fwBad_reg <= sumBad;
                                end else if (idx_reg == CFG_END) begin
                                    cfgBad_reg <= sumBad;
                                end else begin
                                    logBad_reg <= sumBad;
                                end
                            end else begin
                                sum_reg <= sum_reg + rdWord;
                            end
                            idx_reg <= idx_reg + AW'(1);
                            if (idx_reg == LOG_END) begin
                                state_reg <= config_integrity_pkg::ST_EVAL;
                            end else begin
                                state_reg <= config_integrity_pkg::ST_REQ;
                            end
                        end
                    end
                    config_integrity_pkg::ST_EVAL: begin
                        if (logBad_reg) begin
                            flashLogEraseReq <= 1'b1;
                            state_reg <= config_integrity_pkg::ST_ERASE;
                        end else begin
                            state_reg <= config_integrity_pkg::ST_RUN;
                        end
                    end
                    config_integrity_pkg::ST_ERASE: begin
                        if (flashEraseDone) begin
                            state_reg <= config_integrity_pkg::ST_RUN;
                        end
                    end
                    config_integrity_pkg::ST_RUN: begin
                        state_reg <= config_integrity_pkg::ST_RUN;
                    end
                    default: begin
                        state_reg <= config_integrity_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // outcome of the scan; config stays loaded until the next reset
    logic rewriteSeen_reg;
    logic isEval;
    assign isEval = (state_reg == config_integrity_pkg::ST_EVAL) && !softRst;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fwRunEn <= 1'b0;
            cfgDefaultSel <= 1'b0;
            cfgCrcFlag <= 1'b0;
            testPortEn <= 1'b0;
            logEnable <= 1'b0;
            initDone <= 1'b0;
            bus_alert_out_n <= 1'b1;
        end else if (clkEn) begin
            if (softRst) begin
                fwRunEn <= 1'b0;
                testPortEn <= 1'b0;
                logEnable <= 1'b0;
                initDone <= 1'b0;
            end else if (isEval) begin
                fwRunEn <= !fwBad_reg;
                cfgDefaultSel <= cfgBad_reg;
                testPortEn <= blank_reg || (addrDecoded == `ADDR_TESTPORT);
            end else if (state_reg == config_integrity_pkg::ST_RUN) begin
                initDone <= 1'b1;
                logEnable <= !rewriteSeen_reg;
            end
            if (isEval && cfgBad_reg) begin
                cfgCrcFlag <= 1'b1;
            end else if (alertClear) begin
                cfgCrcFlag <= 1'b0;
            end
            bus_alert_out_n <= !cfgCrcFlag;
        end
    end

    // host flash write path, ignored while write protected
    logic hostWr;
    logic hostErase;
    assign hostWr = progWpOff && progWrValid && initDone;
    assign hostErase = progWpOff && progEraseReq && initDone;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flashWrEn <= 1'b0;
            flashWrAddr <= '0;
            flashWrWord <= '0;
            flashChipEraseReq <= 1'b0;
            rewriteSeen_reg <= 1'b0;
        end else if (clkEn) begin
            flashWrEn <= hostWr;
            flashChipEraseReq <= hostErase;
            if (hostWr) begin
                flashWrAddr <= progWrAddr;
                flashWrWord <= {eccBus.wrCheck, progWrData};
            end
            if (softRst) begin
                rewriteSeen_reg <= 1'b0;
            end else if (hostWr || hostErase) begin
                rewriteSeen_reg <= 1'b1;
            end
        end
    end

    // parameter range check
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            paramAccept <= 1'b0;
            paramReject <= 1'b0;
            paramReg <= '0;
        end else if (clkEn) begin
            paramAccept <= 1'b0;
            paramReject <= 1'b0;
            if (paramValid) begin
                if (paramValue >= paramMin && paramValue <= paramMax) begin
                    paramAccept <= 1'b1;
                    paramReg <= paramValue;
                end else begin
                    paramReject <= 1'b1;
                end
            end
        end
    end

    // shared pins: programming port only, never boundary scan
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinOut <= 4'h0;
            pinOe <= 4'h0;
            tapIn <= 3'h0;
            fast_pwm_out <= 1'b0;
        end else if (clkEn) begin
            if (softRst) begin
                pinOe <= 4'h0;
                fast_pwm_out <= 1'b0;
                tapIn <= 3'h0;
            end else if (testPortEn) begin
                pinOut <= {tapTdo, 3'h0};
                pinOe <= `TAP_OE;
                tapIn <= syncStable_reg[10:8];
                fast_pwm_out <= appPwm;
            end else begin
                pinOut <= appGpioOut;
                pinOe <= appGpioOe;
                tapIn <= 3'h0;
                fast_pwm_out <= appPwm;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_reset_pins: assert property (clkEn && softRst |=> pinOe == 4'h0 && !fast_pwm_out)
        else $error("pins driven during watchdog reset");
    chk_port_default: assert property (clkEn && !isEval && !testPortEn |=> !testPortEn)
        else $error("test port enabled outside evaluation");
    chk_port_blank: assert property (clkEn && isEval && blank_reg |=> testPortEn)
        else $error("blank flash did not enable test port");
    chk_port_addr: assert property (clkEn && isEval && addrDecoded == 7'h7E |=> testPortEn)
        else $error("address 126 did not enable test port");
    chk_fw_gate: assert property (clkEn && isEval && fwBad_reg |=> !fwRunEn)
        else $error("firmware run with bad checksum");
    chk_cfg_alert: assert property (clkEn && isEval && cfgBad_reg |=> cfgDefaultSel ##1
        (!bus_alert_out_n || !clkEn))
        else $error("config mismatch did not raise alert");
    chk_log_erase: assert property (clkEn && isEval && logBad_reg |=> flashLogEraseReq)
        else $error("bad log not erased");
    chk_wdt_reset: assert property (clkEn && wdFire |=> softRst && state_reg ==
        config_integrity_pkg::ST_RUN ##1 (!clkEn || state_reg == config_integrity_pkg::ST_IDLE))
        else $error("watchdog did not reset");
    chk_param_range: assert property (clkEn && paramValid && paramValue > paramMax
        |=> paramReject && !paramAccept)
        else $error("out of range parameter accepted");
    chk_rewrite_log: assert property (clkEn && hostWr && !softRst |=> ##1
        (!clkEn || !logEnable))
        else $error("fault logging on after rewrite");
    chk_ecc_store: assert property (clkEn && hostWr |=> flashWrWord[31:0] == $past(progWrData)
        && flashWrWord[37:32] == $past(eccBus.wrCheck))
        else $error("check bits not stored");

    cov_blank_boot: cover property (isEval && blank_reg);
    cov_log_erase: cover property (flashLogEraseReq ##[1:50] initDone);
    cov_wdt_fire: cover property (wdFire);
    cov_rewrite: cover property (hostWr ##[1:20] !logEnable);
endmodule
`default_nettype wire

//--- verilog/config_integrity_defs.svh
// offsets, codes, reset values and timing counts for the integrity block
`ifndef CONFIG_INTEGRITY_DEFS_SVH
`define CONFIG_INTEGRITY_DEFS_SVH
`define ADDR_TESTPORT 7'h7E
`define STRAP_SHORT 4'h0
`define STRAP_OPEN 4'hF
`define BLANK_WORD 32'hFFFFFFFF
`define FW_WORDS 16
`define CFG_WORDS 16
`define LOG_WORDS 16
`define FLASH_AW 8
`define PARAM_W 16
`define CLK_MHZ 25
`define WDT_TIMEOUT_US 1000
`define WDT_CYCLES (`WDT_TIMEOUT_US * `CLK_MHZ)
`define RST_HOLD 4'h8
`define ECC_DW 32
`define ECC_CW 6
`define TAP_OE 4'h8
`endif

//--- verilog/config_integrity_pkg.sv
// types shared by the integrity block
package config_integrity_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_WAIT = 3'b010,
        ST_EVAL = 3'b011,
        ST_ERASE = 3'b100,
        ST_RUN = 3'b101
    } init_state_e;
    typedef logic [37:0] code_word_t;
endpackage

//--- verilog/ecc_if.sv
// link between the integrity block and its flash codec
`timescale 1ns/100ps
`default_nettype none
`include "config_integrity_defs.svh"
interface ecc_if;
    logic [`ECC_DW-1:0] wrData;
    logic [`ECC_CW-1:0] wrCheck;
    config_integrity_pkg::code_word_t rdWord;
    logic [`ECC_DW-1:0] rdData;
    logic rdCorrected;
    logic rdUncorrectable;
    modport codec (input wrData, input rdWord, output wrCheck, output rdData,
        output rdCorrected, output rdUncorrectable);
    modport user (output wrData, output rdWord, input wrCheck, input rdData,
        input rdCorrected, input rdUncorrectable);
endinterface
`default_nettype wire

//--- verilog/ecc_hamming.sv
// hamming codec, six check bits over a 32-bit flash word
`timescale 1ns/100ps
`default_nettype none
`include "config_integrity_defs.svh"
module ecc_hamming (
    ecc_if.codec ecc
);
    function automatic logic [5:0] posOf(input int k);
        int n;
        n = 0;
        posOf = 6'h00;
        for (int j = 3; j < 39; j++) begin
            if ((j & (j - 1)) != 0) begin
                if (n == k) begin
                    posOf = 6'(j);
                end
                n++;
            end
        end
    endfunction

    logic [5:0] wrPos [`ECC_DW];
    logic [5:0] rdPos [`ECC_DW];
    logic [`ECC_DW-1:0] hit;
    logic [5:0] wrAcc;
    logic [5:0] rdAcc;
    logic [5:0] syn;
    logic synPow2;

    genvar k;
    generate
        for (k = 0; k < `ECC_DW; k++) begin : g_bit
            localparam logic [5:0] P = posOf(k);
            assign wrPos[k] = ecc.wrData[k] ? P : 6'h00;
            assign rdPos[k] = ecc.rdWord[k] ? P : 6'h00;
            assign hit[k] = (syn == P);
        end
    endgenerate

    always_comb begin
        wrAcc = 6'h00;
        rdAcc = 6'h00;
        for (int i = 0; i < `ECC_DW; i++) begin
            wrAcc = wrAcc ^ wrPos[i];
            rdAcc = rdAcc ^ rdPos[i];
        end
        syn = rdAcc ^ ecc.rdWord[37:32];
    end

    assign synPow2 = (syn != 6'h00) && ((syn & (syn - 6'h01)) == 6'h00);
    assign ecc.wrCheck = wrAcc;
    assign ecc.rdData = ecc.rdWord[31:0] ^ hit;
    assign ecc.rdCorrected = (syn != 6'h00) && ((|hit) || synPow2);
    assign ecc.rdUncorrectable = (syn != 6'h00) && !((|hit) || synPow2);
endmodule
`default_nettype wire

//--- dv/flash_model.sv
// flash array model answering the scan, log erase and host write traffic
`timescale 1ns/100ps
`default_nettype none
module flash_model #(
    parameter logic [37:0] BLANK = 38'h3F_FFFF_FFFF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic flashRdReq,
    input wire logic [7:0] flashRdAddr,
    output logic [37:0] flashRdWord,
    output logic flashRdAck,
    input wire logic flashLogEraseReq,
    output logic flashEraseDone,
    input wire logic flashWrEn,
    input wire logic [7:0] flashWrAddr,
    input wire logic [37:0] flashWrWord,
    input wire logic flashChipEraseReq
);
    logic [37:0] mem [256];
    logic [2:0] waitCnt;
    logic [2:0] eraseCnt;
    // odd words answer slowly, even words promptly
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            flashRdAck <= 1'h0;
            flashRdWord <= 38'h0;
            waitCnt <= 3'h0;
            eraseCnt <= 3'h0;
            flashEraseDone <= 1'h0;
        end else begin
            flashRdAck <= 1'h0;
            flashRdWord <= ~flashRdWord;
            if (flashRdReq && !flashRdAck) begin
                waitCnt <= waitCnt + 3'h1;
                if (waitCnt >= {1'h0, flashRdAddr[0], 1'h0}) begin
                    flashRdAck <= 1'h1;
                    flashRdWord <= mem[flashRdAddr];
                    waitCnt <= 3'h0;
                end
            end
            if (flashLogEraseReq) begin
                eraseCnt <= 3'h5;
            end else if (eraseCnt != 3'h0) begin
                eraseCnt <= eraseCnt - 3'h1;
            end
            flashEraseDone <= eraseCnt == 3'h1;
            if (eraseCnt == 3'h1) begin
                mem[4] <= BLANK;
                mem[5] <= BLANK;
            end
            if (flashChipEraseReq) begin
                for (int i = 0; i < 256; i++) mem[i] <= BLANK;
            end
            if (flashWrEn) mem[flashWrAddr] <= flashWrWord;
        end
    end
endmodule
`default_nettype wire

//--- dv/config_integrity_and_test_port_enable_test.sv
// self-checking bench for the integrity block
`timescale 1ns/100ps
`default_nettype none
module config_integrity_and_test_port_enable_test;
    logic clk_sys = 1'h0, rst = 1'h1, clkEn = 1'h1, appPwm = 1'h1, tapTdo = 1'h0;
    logic progWpOff = 1'h0, progEraseReq = 1'h0, progWrValid = 1'h0, paramValid = 1'h0;
    logic wdKick = 1'h0, alertClear = 1'h0, flashRdAck, flashEraseDone;
    logic [3:0] pinIn = 4'h7, appGpioOut = 4'hA, appGpioOe = 4'h5;
    logic [3:0] addrStrapHi = 4'h3, addrStrapLo = 4'h5, pinOut, pinOe;
    logic [7:0] progWrAddr = 8'h0, flashRdAddr, flashWrAddr;
    logic [31:0] progWrData = 32'h0;
    logic [15:0] paramValue = 16'h0, paramMin = 16'h10, paramMax = 16'h20, paramReg;
    logic flashRdReq, flashLogEraseReq, flashWrEn, flashChipEraseReq, paramAccept;
    logic paramReject, testPortEn, fast_pwm_out, fwRunEn, cfgDefaultSel, cfgCrcFlag;
    logic logEnable, initDone, eccFixPulse, bus_alert_out_n;
    logic [2:0] tapIn;
    config_integrity_pkg::code_word_t flashRdWord, flashWrWord;
    int failCount = 0, numChecks = 0, fixes, erases;
    // flags fw/cfg/log bad and flip, blank 8 / port expected 4, strap hi, strap lo
    logic [15:0] rows [8] = '{16'h0035, 16'h8035, 16'h4035, 16'h2035, 16'h1035,
        16'h0405, 16'h043F, 16'h0C35};
    logic [15:0] pv [4] = '{16'h000F, 16'h0010, 16'h0020, 16'h0021};
    function automatic logic [5:0] enc(input logic [31:0] d);
        int p;
        logic [5:0] c;
        p = 2;
        c = 6'h0;
        for (int i = 0; i < 32; i++) begin
            p++;
            while ((p & (p - 1)) == 0) p++;
            if (d[i]) c ^= p[5:0];
        end
        return c;
    endfunction
    config_integrity #(.WDT_CYCLES(64), .FW_WORDS(2), .CFG_WORDS(2), .LOG_WORDS(2))
        u_config_integrity (.*);
    flash_model #(.BLANK({enc(32'hFFFF_FFFF), 32'hFFFF_FFFF})) u_flash_model (.*);
    always #20 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        fixes += eccFixPulse === 1'h1;
        erases += flashLogEraseReq === 1'h1;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        numChecks++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // region word then its checksum; bad regions get checksum plus one
    function automatic logic [31:0] img(input int a, input logic [15:0] r);
        if (r[11]) return 32'hFFFF_FFFF;
        return 32'h1234_5600 + 32'(a - a % 2) + 32'(a % 2 == 1 && r[15 - a / 2]);
    endfunction
    task automatic wait_init();
        for (int i = 0; i < 300 && initDone !== 1'h1; i++) @(negedge clk_sys);
        chk(initDone, 38'h1);
    endtask
    task automatic boot(input logic [3:0] h, input logic [3:0] l);
        @(posedge clk_sys) begin
            rst <= 1'h1;
            addrStrapHi <= h;
            addrStrapLo <= l;
        end
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({testPortEn, fast_pwm_out, bus_alert_out_n, pinOe}, 38'h10);
        @(posedge clk_sys) rst <= 1'h0;
        wait_init();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp);
        @(posedge clk_sys) begin
            progWrValid <= 1'h1;
            wdKick <= 1'h1;
            progWrAddr <= a;
            progWrData <= d;
        end
        @(posedge clk_sys) begin
            progWrValid <= 1'h0;
            wdKick <= 1'h0;
        end
        for (int i = 0; i < 3 && flashWrEn !== 1'h1; i++) @(negedge clk_sys);
        chk(flashWrEn, 38'(exp));
        if (exp) chk({flashWrAddr, flashWrWord}, {a, enc(d), d});
    endtask
    initial begin
        #400000;
        failCount++;
        report_and_stop();
    end
    initial begin
        foreach (rows[k]) begin
            for (int a = 0; a < 6; a++) begin
                u_flash_model.mem[a] = {enc(img(a, rows[k])), img(a, rows[k])}
                    ^ 38'(rows[k][12] && a == 0);
            end
            fixes = 0;
            erases = 0;
            boot(rows[k][7:4], rows[k][3:0]);
            @(negedge clk_sys);
            chk({fwRunEn, cfgDefaultSel, cfgCrcFlag, bus_alert_out_n, testPortEn},
                {~rows[k][15], {2{rows[k][14]}}, ~rows[k][14], rows[k][10]});
            chk({pinOe, pinOut[3], tapIn}, rows[k][10] ? 38'h87 : 38'h58);
            chk({fixes != 0, erases[1:0]}, {rows[k][12], 1'h0, rows[k][13]});
            if (rows[k][14]) begin
                @(posedge clk_sys) alertClear <= 1'h1;
                @(posedge clk_sys) alertClear <= 1'h0;
                repeat (2) @(negedge clk_sys);
                chk({cfgCrcFlag, bus_alert_out_n}, 38'h1);
            end
        end
        foreach (pv[i]) begin
            @(posedge clk_sys) begin
                paramValid <= 1'h1;
                wdKick <= 1'h1;
                paramValue <= pv[i];
            end
            @(posedge clk_sys) begin
                paramValid <= 1'h0;
                wdKick <= 1'h0;
            end
            @(negedge clk_sys);
            chk({paramAccept, paramReject}, (i == 1 || i == 2) ? 38'h2 : 38'h1);
        end
        chk(paramReg, 38'h20);
        @(posedge clk_sys) clkEn <= 1'h0;
        repeat (100) @(negedge clk_sys);
        chk(fwRunEn, 38'h1);
        @(posedge clk_sys) clkEn <= 1'h1;
        repeat (6) begin
            @(posedge clk_sys) wdKick <= 1'h1;
            @(posedge clk_sys) wdKick <= 1'h0;
            repeat (40) @(posedge clk_sys);
        end
        chk({initDone, fwRunEn}, 38'h3);
        for (int i = 0; i < 100 && fwRunEn === 1'h1; i++) @(negedge clk_sys);
        chk({fwRunEn, pinOe, fast_pwm_out}, 38'h0);
        wait_init();
        wr(8'h0, 32'h0, 1'h0);
        @(posedge clk_sys) begin
            progWpOff <= 1'h1;
            progEraseReq <= 1'h1;
        end
        @(posedge clk_sys) progEraseReq <= 1'h0;
        repeat (2) @(negedge clk_sys);
        chk(logEnable, 38'h0);
        for (int a = 0; a < 6; a++) wr(8'(a), img(a, 16'h0), 1'h1);
        chk({fwRunEn, cfgDefaultSel, logEnable}, 38'h4);
        @(posedge clk_sys) progWpOff <= 1'h0;
        boot(4'h3, 4'h5);
        chk({fwRunEn, cfgDefaultSel, testPortEn, logEnable}, 38'h9);
        report_and_stop();
    end
endmodule
`default_nettype wire
